// file: src/ue0_pkg.sv
package ue0_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_IN_BCNT  = 16'hff81;
	localparam logic [15:0] IDX_OUT_CFG  = 16'hff82;
	localparam logic [15:0] IDX_OUT_BCNT = 16'hff83;
	localparam logic [15:0] IDX_IRQ_STAT = 16'hff84;
	localparam logic [15:0] IDX_IRQ_MASK = 16'hff85;

	// field positions
	localparam int NAK_BIT   = 7;
	localparam int IE_BIT    = 2;
	localparam int STALL_BIT = 3;
	localparam int TOG_BIT   = 5;
	localparam int BUF_MANAGER_ENABLE_BIT  = 7;
	localparam int IRQ_OUT   = 0;
	localparam int IRQ_IN    = 1;
	localparam int IRQ_SETUP = 2;
	localparam int IRQ_STALL = 3;
	localparam int IRQ_W     = 4;

	// reset values, count limit and word transfer size
	localparam logic [3:0]        CNT_RST  = 4'h0;
	localparam logic              NAK_RST  = 1'b1;
	localparam logic              CFG_RST  = 1'b0;
	localparam logic [IRQ_W-1:0]  IRQ_RST  = 4'h0;
	localparam logic [3:0]        CNT_MAX  = 4'h8;
	localparam logic [2:0]        HSIZE_W  = 3'h2;

	typedef enum logic [1:0] {TOK_SETUP, TOK_OUT, TOK_IN, TOK_IN_ACK} ue0_tok_t;
	typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL, HS_DATA} ue0_hs_t;
	typedef enum logic [2:0] {
		SEL_NONE, SEL_IN_BCNT, SEL_OUT_CFG, SEL_OUT_BCNT, SEL_IRQ_STAT, SEL_IRQ_MASK
	} ue0_sel_t;

	typedef struct packed {
		logic       valid;
		ue0_tok_t   kind;
		logic       data1;
		logic [3:0] len;
	} ue0_host_req_t;

	typedef struct packed {
		logic       valid;
		ue0_hs_t    hs;
		logic       data1;
		logic [3:0] len;
	} ue0_dev_ans_t;

	typedef struct packed {
		logic out_store;
		logic in_sent;
		logic setup_seen;
		logic stall_sent;
		logic tog_flip;
		logic tog_set;
	} ue0_evt_t;

	function automatic logic [3:0] ue0_eff_len(input logic [3:0] c);
		return (c > CNT_MAX) ? CNT_MAX : c;
	endfunction

	function automatic ue0_sel_t ue0_decode(input logic [31:0] a);
		if (a[31:18] != 14'h0000 || a[1:0] != 2'h0)
			return SEL_NONE;
		case (a[17:2])
			IDX_IN_BCNT:  return SEL_IN_BCNT;
			IDX_OUT_CFG:  return SEL_OUT_CFG;
			IDX_OUT_BCNT: return SEL_OUT_BCNT;
			IDX_IRQ_STAT: return SEL_IRQ_STAT;
			IDX_IRQ_MASK: return SEL_IRQ_MASK;
			default:      return SEL_NONE;
		endcase
	endfunction

endpackage

// file: src/ue0_txn.sv
`timescale 1ns/10ps
module ue0_txn import ue0_pkg::*; (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          ce,
	input  ue0_host_req_t      req,
	input  wire logic          buf_manager_enable,
	input  wire logic          stall,
	input  wire logic          in_nak,
	input  wire logic          out_nak,
	input  wire logic          tog,
	input  wire logic [3:0]    in_len,
	output ue0_dev_ans_t       ans_q,
	output ue0_evt_t           evt
);
	ue0_dev_ans_t ans_d;

	// decides the answer to one host token
	always_comb begin
		ans_d = '0;
		evt   = '0;
		if (req.valid && buf_manager_enable) begin
			case (req.kind)
				TOK_SETUP: begin
					ans_d.valid    = 1'b1;
					ans_d.hs       = HS_ACK;
					evt.setup_seen = 1'b1;
					evt.out_store  = 1'b1;
					evt.tog_set    = 1'b1;
				end
				TOK_OUT: begin
					ans_d.valid = 1'b1;
					if (stall) begin
						ans_d.hs       = HS_STALL;
						evt.stall_sent = 1'b1;
					end else if (out_nak) begin
						ans_d.hs = HS_NAK;
					end else begin
						ans_d.hs = HS_ACK;
						// repeated packet with stale toggle is acked, not stored
						evt.out_store = (req.data1 == tog);
						evt.tog_flip  = (req.data1 == tog);
					end
				end
				TOK_IN: begin
					ans_d.valid = 1'b1;
					if (stall) begin
						ans_d.hs       = HS_STALL;
						evt.stall_sent = 1'b1;
					end else if (in_nak) begin
						ans_d.hs = HS_NAK;
					end else begin
						ans_d.hs    = HS_DATA;
						ans_d.data1 = tog;
						ans_d.len   = in_len;
					end
				end
				TOK_IN_ACK: begin
					evt.in_sent  = !in_nak;
					evt.tog_flip = !in_nak;
				end
				default: ans_d = '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ans_q <= '0;
		else if (ce)
			ans_q <= ans_d;
	end

endmodule

// file: src/ue0_ep0_regs.sv
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
// How it works
// - byte counts hold four-bit length, reset zero
// - codes above eight act as eight bytes
// - output busy flag resets set, naks OUT
// - output flag clear accepts host OUT data
// - input flag set naks IN, resets set
// - interrupt enable gates completion events, resets zero
// - stall bit answers STALL, cleared by hardware
// - read-only toggle shows DATA0/DATA1 sequence
// - buffer manager enable gates endpoint service
module ue0_ep0_regs import ue0_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  ue0_host_req_t    host_req,
	output ue0_dev_ans_t     dev_ans,
	output logic             irq
);
	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} ue0_bus_st_t;

	ue0_bus_st_t       state_q;
	ue0_bus_st_t       state_d;
	ue0_sel_t          sel_q;
	ue0_evt_t          evt;
	logic [3:0]        in_cnt_q;
	logic [3:0]        in_cnt_d;
	logic              in_nak_q;
	logic              in_nak_d;
	logic [3:0]        out_cnt_q;
	logic [3:0]        out_cnt_d;
	logic              out_nak_q;
	logic              out_nak_d;
	logic              ie_q;
	logic              stall_q;
	logic              stall_d;
	logic              tog_q;
	logic              tog_d;
	logic              buf_manager_enable_q;
	logic [IRQ_W-1:0]  irq_stat_q;
	logic [IRQ_W-1:0]  irq_stat_d;
	logic [IRQ_W-1:0]  irq_mask_q;
	logic [IRQ_W-1:0]  irq_set;
	logic [IRQ_W-1:0]  irq_clr;
	logic              irq_q;
	logic [31:0]       hrdata_q;
	logic              hreadyout_q;
	logic              hresp_q;
	logic [7:0]        rd_byte;
	wire               accept;
	wire               wr;
	wire               wr_in_bcnt;
	wire               wr_out_cfg;
	wire               wr_out_bcnt;
	wire               wr_stat;
	wire               wr_mask;
	wire ue0_sel_t     addr_sel;

	// bus address phase
	assign addr_sel = ue0_decode(haddr);
	assign accept   = hsel && hready && htrans[1] && hsize == HSIZE_W;

	always_comb begin
		state_d = ST_IDLE;
		case (state_q)
			ST_READ: state_d = ST_IDLE;
			ST_IDLE,
			ST_WRITE: begin
				if (accept)
					state_d = hwrite ? ST_WRITE : ST_READ;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
			sel_q   <= SEL_NONE;
		end else if (ce) begin
			state_q <= state_d;
			if (accept && state_q != ST_READ)
				sel_q <= addr_sel;
		end
	end

	// write strobes, data phase
	assign wr          = ce && state_q == ST_WRITE;
	assign wr_in_bcnt  = wr && sel_q == SEL_IN_BCNT;
	assign wr_out_cfg  = wr && sel_q == SEL_OUT_CFG;
	assign wr_out_bcnt = wr && sel_q == SEL_OUT_BCNT;
	assign wr_stat     = wr && sel_q == SEL_IRQ_STAT;
	assign wr_mask     = wr && sel_q == SEL_IRQ_MASK;

	ue0_txn u_txn (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.req     (host_req),
		.buf_manager_enable    (buf_manager_enable_q),
		.stall   (stall_q),
		.in_nak  (in_nak_q),
		.out_nak (out_nak_q),
		.tog     (tog_q),
		.in_len  (ue0_eff_len(in_cnt_q)),
		.ans_q   (dev_ans),
		.evt     (evt)
	);

	// hardware events win over same-cycle software writes
	assign in_cnt_d  = wr_in_bcnt ? hwdata[3:0] : in_cnt_q;
	assign in_nak_d  = evt.in_sent ? 1'b1 :
		(wr_in_bcnt ? hwdata[NAK_BIT] : in_nak_q);
	assign out_cnt_d = evt.out_store ? ue0_eff_len(host_req.len) :
		(wr_out_bcnt ? hwdata[3:0] : out_cnt_q);
	assign out_nak_d = evt.out_store ? 1'b1 :
		(wr_out_bcnt ? hwdata[NAK_BIT] : out_nak_q);
	assign stall_d   = evt.setup_seen ? 1'b0 :
		(wr_out_cfg ? hwdata[STALL_BIT] : stall_q);
	assign tog_d     = evt.tog_set ? 1'b1 :
		(evt.tog_flip ? ~tog_q : tog_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_cnt_q  <= CNT_RST;
			in_nak_q  <= NAK_RST;
			out_cnt_q <= CNT_RST;
			out_nak_q <= NAK_RST;
		end else if (ce) begin
			in_cnt_q  <= in_cnt_d;
			in_nak_q  <= in_nak_d;
			out_cnt_q <= out_cnt_d;
			out_nak_q <= out_nak_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ie_q    <= CFG_RST;
			stall_q <= CFG_RST;
			tog_q   <= CFG_RST;
			buf_manager_enable_q  <= CFG_RST;
		end else if (ce) begin
			stall_q <= stall_d;
			tog_q   <= tog_d;
			if (wr_out_cfg) begin
				ie_q   <= hwdata[IE_BIT];
				buf_manager_enable_q <= hwdata[BUF_MANAGER_ENABLE_BIT];
			end
		end
	end

	// sticky events, write one to clear; a set in the same cycle wins
	assign irq_set[IRQ_OUT]   = evt.out_store && !evt.setup_seen && ie_q;
	assign irq_set[IRQ_IN]    = evt.in_sent && ie_q;
	assign irq_set[IRQ_SETUP] = evt.setup_seen && ie_q;
	assign irq_set[IRQ_STALL] = evt.stall_sent;
	assign irq_clr            = wr_stat ? hwdata[IRQ_W-1:0] : IRQ_RST;
	assign irq_stat_d         = irq_set | (irq_stat_q & ~irq_clr);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= IRQ_RST;
			irq_mask_q <= IRQ_RST;
			irq_q      <= 1'b0;
		end else if (ce) begin
			irq_stat_q <= irq_stat_d;
			if (wr_mask)
				irq_mask_q <= hwdata[IRQ_W-1:0];
			irq_q <= |(irq_stat_d & (wr_mask ? hwdata[IRQ_W-1:0] : irq_mask_q));
		end
	end

	// read data, reserved bits zero
	always_comb begin
		rd_byte = 8'h00;
		case (sel_q)
			SEL_IN_BCNT:  rd_byte = {in_nak_q, 3'h0, in_cnt_q};
			SEL_OUT_BCNT: rd_byte = {out_nak_q, 3'h0, out_cnt_q};
			SEL_OUT_CFG:  rd_byte = {buf_manager_enable_q, 1'b0, tog_q, 1'b0, stall_q, ie_q, 2'h0};
			SEL_IRQ_STAT: rd_byte = {4'h0, irq_stat_q};
			SEL_IRQ_MASK: rd_byte = {4'h0, irq_mask_q};
			default:      rd_byte = 8'h00;
		endcase
	end

	// reads take one wait state so earlier writes are seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q    <= 32'h0000_0000;
			hreadyout_q <= 1'b1;
			hresp_q     <= 1'b0;
		end else if (ce) begin
			hreadyout_q <= (state_d != ST_READ);
			if (state_q == ST_READ)
				hrdata_q <= {24'h00_0000, rd_byte};
		end
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp     = hresp_q;
	assign irq       = irq_q;

	// checks
	wire tok_ok = ce && host_req.valid && buf_manager_enable_q;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_r1_cnt_write;
		wr_in_bcnt |=> in_cnt_q == $past(hwdata[3:0]);
	endproperty
	a_r1_cnt_write: assert property (p_r1_cnt_write) else $error("count write lost");

	property p_r2_clip;
		tok_ok && host_req.kind == TOK_IN && !stall_q && !in_nak_q
			|=> dev_ans.hs == HS_DATA && dev_ans.len == ue0_eff_len($past(in_cnt_q))
			&& dev_ans.len <= 4'h8;
	endproperty
	a_r2_clip: assert property (p_r2_clip) else $error("IN length wrong");

	property p_r3_out_nak;
		tok_ok && host_req.kind == TOK_OUT && !stall_q && out_nak_q
			|=> dev_ans.valid && dev_ans.hs == HS_NAK;
	endproperty
	a_r3_out_nak: assert property (p_r3_out_nak) else $error("busy OUT not naked");

	property p_r4_out_take;
		tok_ok && host_req.kind == TOK_OUT && !stall_q && !out_nak_q
			&& host_req.data1 == tog_q
			|=> dev_ans.hs == HS_ACK && out_nak_q
			&& out_cnt_q == ue0_eff_len($past(host_req.len)) ##1 !dev_ans.valid || ce;
	endproperty
	a_r4_out_take: assert property (p_r4_out_take) else $error("OUT not taken");

	property p_r5_in_nak;
		tok_ok && host_req.kind == TOK_IN && !stall_q && in_nak_q
			|=> dev_ans.valid && dev_ans.hs == HS_NAK;
	endproperty
	a_r5_in_nak: assert property (p_r5_in_nak) else $error("empty IN not naked");

	property p_r6_no_irq;
		ce && evt.out_store && !ie_q && !irq_stat_q[IRQ_OUT] |=> !irq_stat_q[IRQ_OUT];
	endproperty
	a_r6_no_irq: assert property (p_r6_no_irq) else $error("irq while disabled");

	property p_r7_stall;
		tok_ok && host_req.kind inside {TOK_OUT, TOK_IN} && stall_q
			|=> dev_ans.hs == HS_STALL && irq_stat_q[IRQ_STALL];
	endproperty
	a_r7_stall: assert property (p_r7_stall) else $error("stall not answered");

	property p_r8_toggle;
		!$stable(tog_q) |-> $past(ce && (evt.tog_flip || evt.tog_set));
	endproperty
	a_r8_toggle: assert property (p_r8_toggle) else $error("toggle moved alone");

	property p_r9_gate;
		ce && !buf_manager_enable_q |=> !dev_ans.valid && $stable(out_nak_q) || $past(wr_out_bcnt);
	endproperty
	a_r9_gate: assert property (p_r9_gate) else $error("served while disabled");

	property p_r10_in_sent;
		tok_ok && host_req.kind == TOK_IN_ACK && !in_nak_q |=> in_nak_q;
	endproperty
	a_r10_in_sent: assert property (p_r10_in_sent) else $error("IN flag not set");

	property p_r11_rsv;
		ce && state_q == ST_READ && sel_q == SEL_OUT_CFG
			|=> hrdata[6] == 1'b0 && hrdata[4] == 1'b0 && hrdata[1:0] == 2'h0
			&& hreadyout;
	endproperty
	a_r11_rsv: assert property (p_r11_rsv) else $error("reserved bit set");

	property p_irq_level;
		irq == |(irq_stat_q & irq_mask_q);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	c_out_taken: cover property (tok_ok && host_req.kind == TOK_OUT && !out_nak_q ##1 irq);
	c_in_sent:   cover property (tok_ok && host_req.kind == TOK_IN_ACK && !in_nak_q);
	c_stall:     cover property (dev_ans.valid && dev_ans.hs == HS_STALL);
	c_read:      cover property (state_q == ST_READ ##1 hreadyout);

endmodule

// file: tb/ue0_host_model.sv
`timescale 1ns/10ps
module ue0_host_model import ue0_pkg::*; (
	input  wire logic     hclk,
	output ue0_host_req_t host_req,
	input  ue0_dev_ans_t  dev_ans
);
	initial host_req = '0;

	// one token a call; caller also offers OUT data while the buffer is busy, to see it naked
	task automatic token(input ue0_tok_t k, input logic d1, input logic [3:0] n,
		output ue0_dev_ans_t a);
		host_req <= '{valid: 1'b1, kind: k, data1: d1, len: n};
		@(posedge hclk);
		// released fields show inverted values, never the stale ones
		host_req <= '{valid: 1'b0, kind: ue0_tok_t'(~k), data1: ~d1, len: ~n};
		#1 a = dev_ans;
	endtask
endmodule

// file: tb/usb_endpoint0_descriptor_regs_tb_top.sv
`timescale 1ns/10ps
module usb_endpoint0_descriptor_regs_tb_top import ue0_pkg::*;;
	logic          hclk;
	logic          hresetn;
	logic          ce;
	logic          hreadyout;
	logic          hwrite;
	logic          hresp;
	logic          irq;
	logic          tog;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [3:0]    c;
	logic [31:0]   haddr;
	logic [31:0]   hwdata;
	logic [31:0]   hrdata;
	logic [31:0]   r;
	ue0_host_req_t host_req;
	ue0_dev_ans_t  dev_ans;
	ue0_dev_ans_t  a;
	int            failures;
	int            tests_run;
	int            i;

	ue0_ep0_regs dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.host_req(host_req), .dev_ans(dev_ans), .irq(irq));
	ue0_host_model host (.hclk(hclk), .host_req(host_req), .dev_ans(dev_ans));

	task automatic report_and_stop();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_ans(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
		tests_run++;
		if ((got & m) !== (exp & m)) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got & m, exp & m);
		end
	endtask

	// ready and read data taken at the rising edge that ends the phase
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 20) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 20)
			failures++;
		r = hrdata;
	endtask

	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
		htrans <= 2'h2;
		haddr  <= {14'h0, idx, 2'h0};
		hwrite <= wr;
		hsize  <= HSIZE_W;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		// let the edge's updates settle before anything is looked at
		#1;
	endtask

	task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk_reg(r, exp);
		chk_reg({31'h0, hresp}, 32'h0);
	endtask

	task automatic tok(input ue0_tok_t k, input logic d1, input logic [3:0] n);
		host.token(k, d1, n, a);
	endtask

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	initial begin
		repeat (3000) @(posedge hclk);
		failures++;
		report_and_stop();
	end

	initial begin
		failures = 0;
		tests_run = 0;
		hresetn = 1'b0;
		ce = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = HSIZE_W;
		haddr = 32'h0;
		hwdata = 32'h0;
		tog = 1'b1;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		ce <= 1'b1;
		@(posedge hclk);
		rd(IDX_IN_BCNT, 32'h80);
		rd(IDX_OUT_CFG, 32'h0);
		rd(IDX_OUT_BCNT, 32'h80);
		rd(IDX_IRQ_MASK, 32'h0);
		bus(1'b1, 16'hff80, 32'hff);
		rd(16'hff80, 32'h0);
		bus(1'b1, IDX_IN_BCNT, 32'hff);
		rd(IDX_IN_BCNT, 32'h8f);
		bus(1'b1, IDX_OUT_CFG, 32'h7b);
		rd(IDX_OUT_CFG, 32'h08);
		tok(TOK_OUT, 1'b0, 4'h5);
		chk_ans(a, 8'h0, 8'h80);
		bus(1'b1, IDX_OUT_CFG, 32'h84);
		tok(TOK_OUT, 1'b0, 4'h5);
		chk_ans(a, {1'b1, HS_NAK, 5'h0}, 8'he0);
		bus(1'b1, IDX_OUT_BCNT, 32'h0);
		tok(TOK_OUT, 1'b0, 4'h5);
		chk_ans(a, {1'b1, HS_ACK, 5'h0}, 8'he0);
		rd(IDX_OUT_BCNT, 32'h85);
		rd(IDX_OUT_CFG, 32'ha4);
		chk_reg({31'h0, irq}, 32'h0);
		rd(IDX_IRQ_STAT, 32'h1);
		bus(1'b1, IDX_IRQ_MASK, 32'hf);
		chk_reg({31'h0, irq}, 32'h1);
		bus(1'b1, IDX_IRQ_STAT, 32'h1);
		rd(IDX_IRQ_STAT, 32'h0);
		chk_reg({31'h0, irq}, 32'h0);
		// counts of zero, at and past the eight-byte limit, and at the top of the field
		for (i = 0; i < 4; i++) begin
			c = 4'(16'hf980 >> (i * 4));
			bus(1'b1, IDX_IN_BCNT, {28'h0, c});
			tok(TOK_IN, 1'b0, 4'h0);
			chk_ans(a, {1'b1, HS_DATA, tog, (c > 4'h8) ? 4'h8 : c}, 8'hff);
			tok(TOK_IN_ACK, 1'b0, 4'h0);
			tog = ~tog;
			tok(TOK_IN, 1'b0, 4'h0);
			chk_ans(a, {1'b1, HS_NAK, 5'h0}, 8'he0);
		end
		bus(1'b1, IDX_OUT_CFG, 32'h88);
		bus(1'b1, IDX_IRQ_STAT, 32'hf);
		tok(TOK_OUT, tog, 4'h1);
		chk_ans(a, {1'b1, HS_STALL, 5'h0}, 8'he0);
		tok(TOK_IN, 1'b0, 4'h0);
		chk_ans(a, {1'b1, HS_STALL, 5'h0}, 8'he0);
		tok(TOK_SETUP, 1'b0, 4'h8);
		chk_ans(a, {1'b1, HS_ACK, 5'h0}, 8'he0);
		rd(IDX_OUT_CFG, 32'ha0);
		rd(IDX_IRQ_STAT, 32'h8);
		rd(IDX_OUT_BCNT, 32'h88);
		report_and_stop();
	end
endmodule
